// [verilog/tti_defs.svh]
// Constants shared by both ends of the teletext insertion link.
// Assumes both ends run on the one system clock named below.
`ifndef TTI_DEFS_SVH
`define TTI_DEFS_SVH

// System clock and fixed sync-to-insert delay
`define TTI_CLK_KHZ        27000
`define TTI_INSERT_NS      10200
`define TTI_INSERT_CYC     ((`TTI_INSERT_NS * `TTI_CLK_KHZ) / 1000000)

// Bit pattern: 37 bits in 144 clocks, short bits every ninth
`define TTI_LINE_BITS      9'h168
`define TTI_GROUP_BITS     6'h25
`define TTI_SHORT_STEP     6'h09
`define TTI_LONG_CYC       3'h4
`define TTI_SHORT_CYC      3'h3
`define TTI_REQ_WIDTH_CYC  13'h057A

// Line counter and pipeline sizes
`define TTI_HCNT_W         12
`define TTI_HCNT_MAX       12'hFFF
`define TTI_PIPE_DEPTH     16

// Output levels on luma and composite while inserting
`define TTI_LVL_LOW        10'h0F0
`define TTI_LVL_STEP       10'h060

`endif

// [verilog/tti_pkg.sv]
// Types and bit-pattern helper for the teletext insertion link.
// Assumes tti_defs.svh is on the include path.
`include "tti_defs.svh"
`default_nettype none
package tti_pkg;

    typedef enum logic [2:0] {
        TTI_IDLE = 3'h1,
        TTI_WAIT = 3'h2,
        TTI_SEND = 3'h4
    } tti_state_t;

    // Bits 10, 19, 28, 37 of each group are three clocks long
    function automatic logic [2:0] tti_bit_len(input logic [5:0] gpos);
        logic short_bit;
        short_bit = (gpos != 6'h01) && ((gpos % `TTI_SHORT_STEP) == 6'h01);
        tti_bit_len = short_bit ? `TTI_SHORT_CYC : `TTI_LONG_CYC;
    endfunction : tti_bit_len

endpackage : tti_pkg
`default_nettype wire

// [verilog/tti_if.sv]
// Request and serial data wires between encoder and teletext source.
// Assumes both ends share one clock; the wires carry no clock.
`default_nettype none
interface tti_if;
    logic teletext_request_out;
    logic teletext_data_in;

    modport enc (output teletext_request_out, input teletext_data_in);
    modport src (input teletext_request_out, output teletext_data_in);
endinterface : tti_if
`default_nettype wire

// [verilog/tti_source.sv]
// Teletext data source end: gated by the request, fixed bit pattern.
// Assumes the request arrives as an asynchronous pin.
`include "tti_defs.svh"
`default_nettype none
module tti_source
    import tti_pkg::*;
(
    input  wire logic        clk_i,
    input  wire logic        rst_b_i,
    tti_if.src               link,
    input  wire logic [3:0]  source_pipeline_delay_i,
    input  wire logic        bit_i,
    output logic             bit_take_o,
    output logic             busy_o
);

    logic       req_meta;
    logic       req_sync;
    logic       req_prev;
    tti_state_t state;
    logic [2:0] phase;
    logic [5:0] gpos;
    logic [8:0] bitn;
    logic       seq_bit;
    logic [`TTI_PIPE_DEPTH-1:0] pipe;
    logic       bit_end;
    logic       start;

    always_ff @(posedge clk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            req_meta <= 1'b0;
            req_sync <= 1'b0;
            req_prev <= 1'b0;
        end
        else
        begin
            req_meta <= link.teletext_request_out;
            req_sync <= req_meta;
            req_prev <= req_sync;
        end
    end

    assign start   = (state == TTI_IDLE) && req_sync && !req_prev;
    assign bit_end = (phase == tti_bit_len(gpos) - 3'h1);
    // Bits are only fetched while the request still gates us
    assign bit_take_o = start ||
        ((state == TTI_SEND) && bit_end && (bitn != `TTI_LINE_BITS) &&
         req_sync);

    always_ff @(posedge clk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            state   <= TTI_IDLE;
            phase   <= 3'h0;
            gpos    <= 6'h01;
            bitn    <= 9'h001;
            seq_bit <= 1'b0;
        end
        else
        begin
            case (state)
                TTI_IDLE:
                begin
                    if (start)
                    begin
                        state   <= TTI_SEND;
                        seq_bit <= bit_i;
                    end
                    phase <= 3'h0;
                    gpos  <= 6'h01;
                    bitn  <= 9'h001;
                end
                TTI_SEND:
                begin
                    phase <= bit_end ? 3'h0 : phase + 3'h1;
                    if (bit_take_o)
                    begin
                        seq_bit <= bit_i;
                        bitn    <= bitn + 9'h001;
                        gpos    <= (gpos == `TTI_GROUP_BITS) ? 6'h01
                                   : gpos + 6'h01;
                    end
                    else if (bit_end)
                    begin
                        state   <= TTI_WAIT;
                        seq_bit <= 1'b0;
                    end
                end
                TTI_WAIT:
                begin
                    // Rearm only after the request has dropped
                    if (!req_sync)
                        state <= TTI_IDLE;
                end
                default:
                    state <= TTI_IDLE;
            endcase
        end
    end

    // Variable pipeline delay between fetch and the data pin
    always_ff @(posedge clk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            pipe                  <= '0;
            link.teletext_data_in <= 1'b0;
        end
        else
        begin
            pipe <= {pipe[`TTI_PIPE_DEPTH-2:0], seq_bit};
            link.teletext_data_in <= (source_pipeline_delay_i == 4'h0)
                ? seq_bit : pipe[source_pipeline_delay_i - 4'h1];
        end
    end

    assign busy_o = (state != TTI_IDLE);

endmodule : tti_source
`default_nettype wire

// [verilog/tti_encoder.sv]
// Encoder end of the teletext insertion port: request window,
// bit sequencer and interpolating insertion onto luma and composite.
// Assumes hsync_i is a one-cycle pulse from the encoder's own timing
// on clk_i, and teletext_data_in arrives as an asynchronous pin.
`include "tti_defs.svh"
`default_nettype none

// Summary of operation
// - Insert data fixed delay after sync leading edge
// - Request edges programmable for any source delay
// - Source sends bits after delay, while requested
// - Request window fits 360 bits at 6.9375M
// - Compliant width when trim field is zero
// - Enable low: no request, no insertion
// - 37 bits take 144 system clocks
// - Bits 10,19,28,37 three clocks, others four
// - Pattern repeats each group until 360 bits
// - Resample with sequencer and interpolation filter
// - Same timing every line, per-line select
module tti_encoder
    import tti_pkg::*;
(
    input  wire logic        clk_i,
    input  wire logic        rst_b_i,
    tti_if.enc               link,
    input  wire logic        hsync_i,
    input  wire logic        teletext_enable_bit_i,
    input  wire logic        line_insert_i,
    input  wire logic [11:0] req_rise_i,
    input  wire logic [3:0]  request_width_trim_i,
    input  wire logic [9:0]  luma_i,
    input  wire logic [9:0]  cvbs_i,
    output logic      [9:0]  luma_o,
    output logic      [9:0]  cvbs_o,
    output logic             inserting_o
);

    localparam logic [`TTI_HCNT_W-1:0] INSERT_AT =
        `TTI_HCNT_W'(`TTI_INSERT_CYC);

    logic                   data_meta;
    logic                   data_sync;
    logic [`TTI_HCNT_W-1:0] hcount;
    logic                   line_on;
    logic [12:0]            req_fall;
    logic                   req_window;
    tti_state_t             state;
    logic [2:0]             phase;
    logic [5:0]             gpos;
    logic [8:0]             bitn;
    logic                   cur_bit;
    logic                   next_cur;
    logic                   bit_end;
    logic                   start;
    logic                   last_bit;
    logic                   allowed;
    logic [2:0]             weight;
    logic [9:0]             ttx_level;

    // Data pin from the source: two flops before any use
    always_ff @(posedge clk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            data_meta <= 1'b0;
            data_sync <= 1'b0;
        end
        else
        begin
            data_meta <= link.teletext_data_in;
            data_sync <= data_meta;
        end
    end

    // Clocks since the sync leading edge, saturating past line end
    always_ff @(posedge clk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
            hcount <= '0;
        else if (hsync_i)
            hcount <= '0;
        else if (hcount != `TTI_HCNT_MAX)
            hcount <= hcount + `TTI_HCNT_W'(1);
    end

    // Per-line selection taken once per line at sync
    always_ff @(posedge clk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
            line_on <= 1'b0;
        else if (hsync_i)
            line_on <= line_insert_i;
    end

    assign allowed = teletext_enable_bit_i && line_on;

    // Trim is a signed offset on the falling edge; zero is compliant
    assign req_fall = {1'b0, req_rise_i} + `TTI_REQ_WIDTH_CYC
                      + {{9{request_width_trim_i[3]}},
                         request_width_trim_i};

    assign req_window = allowed && !hsync_i &&
                        ({1'b0, hcount} >= {1'b0, req_rise_i}) &&
                        ({1'b0, hcount} < req_fall);

    always_ff @(posedge clk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
            link.teletext_request_out <= 1'b0;
        else
            link.teletext_request_out <= req_window;
    end

    // Insertion sequencer: fixed start, independent of request edges
    assign start    = (state == TTI_IDLE) && allowed && !hsync_i &&
                      (hcount == INSERT_AT);
    assign bit_end  = (phase == tti_bit_len(gpos) - 3'h1);
    assign last_bit = (bitn == `TTI_LINE_BITS);

    always_ff @(posedge clk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            state <= TTI_IDLE;
            phase <= 3'h0;
            gpos  <= 6'h01;
            bitn  <= 9'h001;
        end
        else
        begin
            case (state)
                TTI_IDLE:
                begin
                    if (start)
                        state <= TTI_SEND;
                    phase <= 3'h0;
                    gpos  <= 6'h01;
                    bitn  <= 9'h001;
                end
                TTI_SEND:
                begin
                    // Enable drop or a new line closes the window at once
                    if (!teletext_enable_bit_i || hsync_i)
                        state <= TTI_IDLE;
                    else if (bit_end)
                    begin
                        phase <= 3'h0;
                        if (last_bit)
                            state <= TTI_IDLE;
                        bitn <= bitn + 9'h001;
                        gpos <= (gpos == `TTI_GROUP_BITS) ? 6'h01
                                : gpos + 6'h01;
                    end
                    else
                        phase <= phase + 3'h1;
                end
                default:
                    state <= TTI_IDLE;
            endcase
        end
    end

    // Next bit value is taken at start and at the last clock of every bit slot but the final one
    always_comb
    begin
        next_cur = cur_bit;
        if (start)
            next_cur = data_sync;
        else if ((state == TTI_SEND) && bit_end && !last_bit)
            next_cur = data_sync;
    end

    always_ff @(posedge clk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
            cur_bit <= 1'b0;
        else if (state == TTI_IDLE && !start)
            cur_bit <= 1'b0;
        else
            cur_bit <= next_cur;
    end

    // Two-tap interpolation, 3:1 new to old, softens each transition.
    // Trades a little rise time for much less edge jitter.
    assign weight    = {1'b0, next_cur, next_cur} + {2'b00, cur_bit};
    assign ttx_level = `TTI_LVL_LOW + (`TTI_LVL_STEP * {7'h00, weight});

    always_ff @(posedge clk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            luma_o      <= 10'h000;
            cvbs_o      <= 10'h000;
            inserting_o <= 1'b0;
        end
        else if (start ||
                 ((state == TTI_SEND) && teletext_enable_bit_i &&
                  !hsync_i && !(bit_end && last_bit)))
        begin
            luma_o      <= ttx_level;
            cvbs_o      <= ttx_level;
            inserting_o <= 1'b1;
        end
        else
        begin
            luma_o      <= luma_i;
            cvbs_o      <= cvbs_i;
            inserting_o <= 1'b0;
        end
    end

endmodule : tti_encoder
`default_nettype wire

// [verif/tti_link_sva.sv]
// Checker for the teletext link: request window, bit spacing, insertion.
// Assumes one clock; instantiated beside the link interface.
`default_nettype none
module tti_link_sva (
    input wire logic        clk_i,
    input wire logic        rst_b_i,
    input wire logic        teletext_request_out,
    input wire logic        teletext_data_in,
    input wire logic        hsync_i,
    input wire logic        teletext_enable_bit_i,
    input wire logic        line_insert_i,
    input wire logic [11:0] req_rise_i,
    input wire logic [3:0]  request_width_trim_i,
    input wire logic        inserting_o,
    input wire logic        bit_take_o
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [12:0] hc;
    logic [12:0] rq_n;
    logic [12:0] in_n;
    logic [5:0]  pos;
    logic [5:0]  gap;

    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (!rst_b_i);

    always_ff @(posedge clk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            hc   <= 13'h0000;
            rq_n <= 13'h0000;
            in_n <= 13'h0000;
            pos  <= 6'h00;
            gap  <= 6'h00;
        end
        else
        begin
            hc   <= hsync_i ? 13'h0000 : hc + 13'h0001;
            rq_n <= teletext_request_out ? rq_n + 13'h0001 : 13'h0000;
            in_n <= inserting_o ? in_n + 13'h0001 : 13'h0000;
            gap  <= bit_take_o ? 6'h01 : gap + 6'h01;
            // Position is the number of the bit just fetched
            if (!teletext_request_out)
                pos <= 6'h00;
            else if (bit_take_o)
                pos <= (pos == 6'h25) ? 6'h01 : pos + 6'h01;
        end
    end

    sequence s_line;
        hsync_i && teletext_enable_bit_i && line_insert_i;
    endsequence
    sequence s_req_up;
        $rose(teletext_request_out);
    endsequence

    property p_req_off;
        !teletext_enable_bit_i |=> !teletext_request_out;
    endproperty
    a_req_off: assert property (p_req_off)
        else $error("request while disabled");
    property p_ins_off;
        !teletext_enable_bit_i |=> !inserting_o;
    endproperty
    a_ins_off: assert property (p_ins_off)
        else $error("insertion while disabled");
    property p_rise_pos;
        s_req_up |-> hc == {1'b0, req_rise_i} + 13'h0001;
    endproperty
    a_rise_pos: assert property (p_rise_pos)
        else $error("request rose at wrong position");
    property p_req_width;
        $fell(teletext_request_out) && teletext_enable_bit_i |->
            rq_n == 13'h057A + {{9{request_width_trim_i[3]}},
                                request_width_trim_i};
    endproperty
    a_req_width: assert property (p_req_width)
        else $error("request window width wrong");
    property p_ins_width;
        $fell(inserting_o) && teletext_enable_bit_i |-> in_n == 13'h057A;
    endproperty
    a_ins_width: assert property (p_ins_width)
        else $error("insertion length wrong");
    property p_ins_start;
        s_line |-> ##277 $rose(inserting_o);
    endproperty
    a_ins_start: assert property (p_ins_start)
        else $error("insertion start misplaced");
    property p_req_quiet;
        s_req_up |-> !teletext_data_in [*3];
    endproperty
    a_req_quiet: assert property (p_req_quiet)
        else $error("data ahead of source delay");
    property p_bit_gap;
        bit_take_o && pos != 6'h00 |->
            gap == ((pos != 6'h01 && pos % 6'h09 == 6'h01) ? 6'h03 : 6'h04);
    endproperty
    a_bit_gap: assert property (p_bit_gap)
        else $error("bit length wrong");
endmodule : tti_link_sva
`default_nettype wire

// [verif/vbi_teletext_insertion_port_tb_top.sv]
// Bench joining encoder and source ends through the link interface.
// Assumes cycle counts of the 27 MHz pattern; 10 ns clock here.
`default_nettype none
module vbi_teletext_insertion_port_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    typedef struct packed {
        logic        en;
        logic        sel;
        logic        alt;
        logic [3:0]  trim;
        logic [3:0]  dly;
        logic [12:0] rq;
    } tti_row_t;
    logic        clk   = 1'b0;
    logic        rst_b = 1'b0;
    logic        hsync = 1'b0;
    logic        en    = 1'b0;
    logic        sel   = 1'b0;
    logic        alt   = 1'b0;
    logic [3:0]  trim  = 4'h0;
    logic [3:0]  dly   = 4'h0;
    logic [11:0] rise  = 12'h10B;
    logic [12:0] n_rq  = 13'h0000;
    logic [12:0] n_tk  = 13'h0000;
    logic [12:0] n_hi  = 13'h0000;
    logic [12:0] n_lo  = 13'h0000;
    logic [9:0]  luma;
    logic [9:0]  cvbs;
    logic        busy;
    logic        ins;
    logic        take;
    logic        bit_v;
    int          mismatches = 0;
    int          n_checks   = 0;
    int          tcnt       = 0;
    tti_row_t    rows [6]   = '{
        '{1'h1, 1'h1, 1'h0, 4'h0, 4'h0, 13'h057A},
        '{1'h1, 1'h1, 1'h1, 4'h0, 4'h5, 13'h057A},
        '{1'h1, 1'h1, 1'h1, 4'h3, 4'h0, 13'h057D},
        '{1'h0, 1'h1, 1'h0, 4'h0, 4'h0, 13'h0000},
        '{1'h1, 1'h0, 1'h0, 4'h0, 4'h0, 13'h0000},
        '{1'h1, 1'h1, 1'h0, 4'hF, 4'h2, 13'h0579}};

    // Alternating data makes each short bit that carries a one visible in the level count
    assign bit_v = alt ? ~n_tk[0] : 1'b1;

    tti_if i_tti_if ();
    tti_encoder i_tti_encoder (.clk_i(clk), .rst_b_i(rst_b),
        .link(i_tti_if.enc), .hsync_i(hsync), .teletext_enable_bit_i(en),
        .line_insert_i(sel), .req_rise_i(rise), .request_width_trim_i(trim),
        .luma_i(10'h040), .cvbs_i(10'h050), .luma_o(luma), .cvbs_o(cvbs),
        .inserting_o(ins));
    tti_source i_tti_source (.clk_i(clk), .rst_b_i(rst_b),
        .link(i_tti_if.src), .source_pipeline_delay_i(dly), .bit_i(bit_v),
        .bit_take_o(take), .busy_o(busy));
    tti_link_sva i_tti_link_sva (.clk_i(clk), .rst_b_i(rst_b),
        .teletext_request_out(i_tti_if.teletext_request_out),
        .teletext_data_in(i_tti_if.teletext_data_in), .hsync_i(hsync),
        .teletext_enable_bit_i(en), .line_insert_i(sel), .req_rise_i(rise),
        .request_width_trim_i(trim), .inserting_o(ins), .bit_take_o(take));

    initial
    begin
        forever #5 clk = ~clk;
    end

    task automatic summarize;
        $display("checks %0d mismatches %0d", n_checks, mismatches);
        if (mismatches == 0 && n_checks > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask : summarize

    task automatic check(input string what, input logic [12:0] seen, exp);
        n_checks++;
        if (seen !== exp)
        begin
            mismatches++;
            $display("MISMATCH %s expected %0h seen %0h", what, exp, seen);
        end
    endtask : check

    // Cycles at the high level: later clocks of each one bit
    function automatic logic [12:0] hi_exp(input logic a);
        logic [12:0] s;
        int          g;
        s = 13'h0000;
        for (int k = 1; k <= 9'h168; k += 2)
        begin
            g = k % 6'h25;
            s += (g == 0 || (g % 4'h9 == 1 && g != 1)) ? 13'h2 : 13'h3;
        end
        return a ? s : 13'h0579;
    endfunction : hi_exp

    always @(posedge clk)
    begin
        tcnt <= tcnt + 1;
        n_rq <= hsync ? 13'h0 : n_rq + i_tti_if.teletext_request_out;
        n_tk <= hsync ? 13'h0 : n_tk + take;
        n_hi <= hsync ? 13'h0
                : n_hi + ((luma === 10'h270) && (cvbs === 10'h270));
        // First clock of a one after a zero: 3:1 blend level
        n_lo <= hsync ? 13'h0 : n_lo + (luma === 10'h210);
        if (tcnt == 20000)
        begin
            mismatches++;
            summarize();
        end
    end

    task automatic start(input tti_row_t r);
        en <= r.en;
        sel <= r.sel;
        alt <= r.alt;
        trim <= r.trim;
        dly <= r.dly;
        rise <= 12'h10B - {8'h00, r.dly};
        @(posedge clk);
        hsync <= 1'b1;
        @(posedge clk);
        hsync <= 1'b0;
    endtask : start

    task automatic quiet(input string what);
        check(what, {3'h0, luma}, rst_b ? 13'h0040 : 13'h0000);
        check(what, {3'h0, cvbs}, rst_b ? 13'h0050 : 13'h0000);
        check(what, {12'h0, i_tti_if.teletext_request_out}, 13'h0);
    endtask : quiet

    task automatic run_chk(input tti_row_t r);
        logic        on;
        logic [12:0] lo;
        on = r.en & r.sel;
        lo = r.alt ? 13'h00B4 : 13'h0001;
        start(r);
        repeat (1750) @(posedge clk);
        #1;
        check("request cycles", n_rq, r.rq);
        check("bits fetched", n_tk, on ? 13'h0168 : 13'h0);
        check("level cycles", n_hi, on ? hi_exp(r.alt) : 13'h0);
        check("blend cycles", n_lo, on ? lo : 13'h0);
        check("source idle", {12'h0, busy}, 13'h0);
        quiet("line end");
    endtask : run_chk

    initial
    begin
        repeat (16) @(posedge clk);
        #1;
        quiet("reset");
        rst_b <= 1'b1;
        foreach (rows[i])
            run_chk(rows[i]);
        start(rows[0]);
        repeat (600) @(posedge clk);
        en <= 1'b0;
        repeat (3) @(posedge clk);
        #1;
        quiet("abort");
        repeat (1200) @(posedge clk);
        start(rows[1]);
        repeat (500) @(posedge clk);
        rst_b <= 1'b0;
        repeat (2) @(posedge clk);
        #1;
        quiet("mid reset");
        rst_b <= 1'b1;
        run_chk(rows[0]);
        summarize();
    end
endmodule : vbi_teletext_insertion_port_tb_top
`default_nettype wire
